// [wakeup_timer_and_sense_status.v]
// What this block does
// R01 - manual cal field steps 0.1 pF to 3.1 pF; zero selects automatic
// R02 - gain code decodes to 2.8, 6.5, 1.1, 0.5, 0.35 V/pF; others unused
// R03 - sensor, readback, aux status, wake control clear at reset and set-default
// R04 - readback shows cal value bits 7..3, cal ended bit 2, error bit 1
// R05 - status bit 7 selected channel, bit 6 external field present
// R06 - status bit 5 high while transmitting
// R07 - status bit 4 high once crystal oscillator is stable
// R08 - status bit 3 high while receive decoder enabled
// R09 - status bit 2 high while a message is being received
// R10 - status bit 1 high in peer detection mode
// R11 - status bit 0 high in collision avoidance mode
// R12 - control bit 7 picks 100 ms or 10 ms base step
// R13 - timeout is (N+1) base steps, N the three-bit field
// R14 - interrupt at every expiry when control bit 3 set
// R15 - bit 2 starts amplitude measurement; interrupt if beyond amplitude threshold
// R16 - bit 1 starts phase measurement; interrupt if beyond phase threshold
// R17 - amplitude threshold is upper four bits of amplitude config
// R18 - config bit picks stored or averaged amplitude reference
// R19 - timer restarts after each expiry while wake-up stays enabled
`timescale 1ns/10ps
`include "wakeup_timer_map.vh"

module wakeup_timer_and_sense_status #(
  parameter STEP_CYCLES = `SHORT_STEP_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [7:0] rdata_o,
  // set-default command
  input wire set_default_i,
  // device status inputs
  input wire chan_sel_pm_i,
  input wire ext_field_i,
  input wire tx_active_i,
  input wire osc_stable_i,
  input wire rx_enabled_i,
  input wire rx_receiving_i,
  input wire peer_detect_i,
  input wire collision_avoid_active_i,
  // capacitive calibration result
  input wire [4:0] cal_value_i,
  input wire cal_done_i,
  input wire cal_error_i,
  // capacitive sensor setup
  output wire [4:0] cap_cal_manual_o,
  output wire auto_cal_en_o,
  output wire [12:0] gain_mv_per_pf_o,
  output wire gain_valid_o,
  // measurement handshake
  output wire amp_meas_req_o,
  input wire amp_done_i,
  input wire [7:0] amp_result_i,
  input wire [7:0] amp_avg_ref_i,
  output wire phase_meas_req_o,
  input wire phase_done_i,
  input wire [7:0] phase_result_i,
  // timer and interrupt
  output wire wake_timeout_o,
  output wire irq_o
);

  reg [7:0] cap_ctrl_r;
  reg [7:0] cap_rb_r;
  reg [7:0] aux_r;
  reg [7:0] wake_ctrl_r;
  reg [7:0] amp_cfg_r;
  reg [7:0] amp_ref_r;
  reg [7:0] ph_cfg_r;
  reg [7:0] ph_ref_r;
  reg wake_en_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg irq_r;
  reg [7:0] rdata_r;

  reg [4:0] mcal_r;
  reg auto_cal_r;
  reg [12:0] gain_mv_r;
  reg gain_ok_r;

  // two-flop synchronisers for status and calibration inputs
  reg [15:0] sync_a_r;
  reg [15:0] sync_b_r;
  reg cal_done_d_r;

  reg [19:0] pre_r;
  reg [6:0] tick_cnt_r;
  reg expire_r;
  reg amp_req_r;
  reg ph_req_r;
  reg amp_busy_r;
  reg ph_busy_r;

  wire [15:0] async_in;
  wire [7:0] aux_nxt;
  wire cal_rise;
  wire run;
  wire tick;
  wire [3:0] tmo_n1;
  wire [6:0] tgt;
  wire expire;
  wire [7:0] amp_ref_use;
  wire [7:0] amp_diff;
  wire [7:0] ph_diff;
  wire amp_hit;
  wire ph_hit;
  wire [2:0] irq_set;
  wire [2:0] irq_clr;
  wire [2:0] irq_stat_nxt;
  wire [2:0] irq_mask_nxt;
  wire [7:0] cap_ctrl_nxt;
  wire wr_cap;
  wire wr_wake;

  assign async_in = {cal_error_i, cal_done_i, cal_value_i, chan_sel_pm_i,
                     ext_field_i, tx_active_i, osc_stable_i, rx_enabled_i,
                     rx_receiving_i, peer_detect_i, collision_avoid_active_i,
                     1'b0};

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_a_r <= 16'h0000;
      sync_b_r <= 16'h0000;
      cal_done_d_r <= 1'b0;
    end else begin
      sync_a_r <= async_in;
      sync_b_r <= sync_a_r;
      cal_done_d_r <= sync_b_r[14];
    end
  end

  // aux status, bit order channel..collision avoid
  assign aux_nxt = {sync_b_r[8], // [R05]
                    sync_b_r[7], // [R05]
                    sync_b_r[6], // [R06]
                    sync_b_r[5], // [R07]
                    sync_b_r[4], // [R08]
                    sync_b_r[3], // [R09]
                    sync_b_r[2], // [R10]
                    sync_b_r[1]}; // [R11]

  assign cal_rise = sync_b_r[14] & ~cal_done_d_r;

  assign wr_cap = wr_i && (addr_i == `OFS_CAP_CTRL);
  assign wr_wake = wr_i && (addr_i == `OFS_WAKE_CTRL);
  assign cap_ctrl_nxt = set_default_i ? `RST_BYTE :
                        wr_cap ? wdata_i : cap_ctrl_r;

  // status and readback registers
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aux_r <= `RST_BYTE;
      cap_rb_r <= `RST_BYTE;
    end else if (set_default_i) begin
      aux_r <= `RST_BYTE; // [R03]
      cap_rb_r <= `RST_BYTE; // [R03]
    end else begin
      aux_r <= aux_nxt;
      if (cal_rise) begin
        cap_rb_r <= {sync_b_r[13:9], 1'b1, sync_b_r[15], 1'b0}; // [R04]
      end
    end
  end

  // software written registers
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_ctrl_r <= `RST_BYTE;
      wake_ctrl_r <= `RST_BYTE;
      amp_cfg_r <= `RST_BYTE;
      amp_ref_r <= `RST_BYTE;
      ph_cfg_r <= `RST_BYTE;
      ph_ref_r <= `RST_BYTE;
      wake_en_r <= 1'b0;
      irq_mask_r <= `RST_IRQ;
    end else if (set_default_i) begin
      cap_ctrl_r <= `RST_BYTE; // [R03]
      wake_ctrl_r <= `RST_BYTE; // [R03]
      amp_cfg_r <= `RST_BYTE;
      amp_ref_r <= `RST_BYTE;
      ph_cfg_r <= `RST_BYTE;
      ph_ref_r <= `RST_BYTE;
      wake_en_r <= 1'b0;
      irq_mask_r <= `RST_IRQ;
    end else if (wr_i) begin
      cap_ctrl_r <= cap_ctrl_nxt;
      if (addr_i == `OFS_WAKE_CTRL) begin
        wake_ctrl_r <= {wdata_i[7:1], 1'b0};
      end else if (addr_i == `OFS_AMP_CFG) begin
        amp_cfg_r <= wdata_i;
      end else if (addr_i == `OFS_AMP_REF) begin
        amp_ref_r <= wdata_i;
      end else if (addr_i == `OFS_PHASE_CFG) begin
        ph_cfg_r <= wdata_i;
      end else if (addr_i == `OFS_PHASE_REF) begin
        ph_ref_r <= wdata_i;
      end else if (addr_i == `OFS_WAKE_ENABLE) begin
        wake_en_r <= wdata_i[0];
      end else if (addr_i == `OFS_IRQ_MASK) begin
        irq_mask_r <= wdata_i[2:0];
      end
    end
  end

  // sensor setup outputs follow the control register
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mcal_r <= 5'h00;
      auto_cal_r <= 1'b1;
      gain_mv_r <= `GAIN_MV_0;
      gain_ok_r <= 1'b1;
    end else begin
      mcal_r <= cap_ctrl_nxt[`CAP_MCAL_HI:`CAP_MCAL_LO]; // [R01]
      auto_cal_r <= (cap_ctrl_nxt[`CAP_MCAL_HI:`CAP_MCAL_LO] == 5'h00); // [R01]
      gain_ok_r <= 1'b1;
      case (cap_ctrl_nxt[`CAP_GAIN_HI:`CAP_GAIN_LO])
        `GAIN_CODE_0: gain_mv_r <= `GAIN_MV_0; // [R02]
        `GAIN_CODE_1: gain_mv_r <= `GAIN_MV_1; // [R02]
        `GAIN_CODE_2: gain_mv_r <= `GAIN_MV_2; // [R02]
        `GAIN_CODE_4: gain_mv_r <= `GAIN_MV_4; // [R02]
        `GAIN_CODE_6: gain_mv_r <= `GAIN_MV_6; // [R02]
        default: begin
          gain_mv_r <= 13'h0000;
          gain_ok_r <= 1'b0;
        end
      endcase
    end
  end

  // wake-up timer: prescaler of one short step, then step ticks
  assign run = wake_en_r && !wr_wake && !set_default_i;
  assign tick = (pre_r == STEP_CYCLES[19:0] - 20'h00001);
  assign tmo_n1 = {1'b0, wake_ctrl_r[`WAKE_TMO_HI:`WAKE_TMO_LO]} + 4'h1; // [R13]
  assign tgt = wake_ctrl_r[`WAKE_RANGE_BIT] ? {3'h0, tmo_n1} : // [R12]
               ({3'h0, tmo_n1} << 3) + ({3'h0, tmo_n1} << 1); // [R12]
  assign expire = run && tick && (tick_cnt_r == tgt - 7'h01); // [R13]

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_r <= 20'h00000;
      tick_cnt_r <= 7'h00;
      expire_r <= 1'b0;
    end else begin
      expire_r <= expire;
      if (!run) begin
        pre_r <= 20'h00000;
        tick_cnt_r <= 7'h00;
      end else if (tick) begin
        pre_r <= 20'h00000;
        if (expire) begin
          tick_cnt_r <= 7'h00; // [R19]
        end else begin
          tick_cnt_r <= tick_cnt_r + 7'h01;
        end
      end else begin
        pre_r <= pre_r + 20'h00001;
      end
    end
  end

  // measurement requests at timeout and result comparison
  assign amp_ref_use = amp_cfg_r[`AMP_REF_SEL_BIT] ? amp_avg_ref_i : amp_ref_r; // [R18]
  assign amp_diff = (amp_result_i > amp_ref_use) ? amp_result_i - amp_ref_use :
                    amp_ref_use - amp_result_i;
  assign ph_diff = (phase_result_i > ph_ref_r) ? phase_result_i - ph_ref_r :
                   ph_ref_r - phase_result_i;
  assign amp_hit = amp_busy_r && amp_done_i &&
                   (amp_diff > {4'h0, amp_cfg_r[`THR_HI:`THR_LO]}); // [R15] [R17]
  assign ph_hit = ph_busy_r && phase_done_i &&
                  (ph_diff > {4'h0, ph_cfg_r[`THR_HI:`THR_LO]}); // [R16]

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      amp_req_r <= 1'b0;
      ph_req_r <= 1'b0;
      amp_busy_r <= 1'b0;
      ph_busy_r <= 1'b0;
    end else if (set_default_i) begin
      amp_req_r <= 1'b0;
      ph_req_r <= 1'b0;
      amp_busy_r <= 1'b0;
      ph_busy_r <= 1'b0;
    end else begin
      amp_req_r <= expire && wake_ctrl_r[`WAKE_AMP_BIT]; // [R15]
      ph_req_r <= expire && wake_ctrl_r[`WAKE_PHASE_BIT]; // [R16]
      if (expire && wake_ctrl_r[`WAKE_AMP_BIT]) begin
        amp_busy_r <= 1'b1;
      end else if (amp_done_i) begin
        amp_busy_r <= 1'b0;
      end
      if (expire && wake_ctrl_r[`WAKE_PHASE_BIT]) begin
        ph_busy_r <= 1'b1;
      end else if (phase_done_i) begin
        ph_busy_r <= 1'b0;
      end
    end
  end

  // interrupt status: write one to clear, a new event wins
  assign irq_set = {ph_hit, amp_hit, expire && wake_ctrl_r[`WAKE_IRQ_BIT]}; // [R14]
  assign irq_clr = (wr_i && (addr_i == `OFS_IRQ_STATUS)) ? wdata_i[2:0] : 3'h0;
  assign irq_stat_nxt = irq_set | (irq_stat_r & ~irq_clr);
  // a mask write reaches the interrupt output at the edge that takes it
  assign irq_mask_nxt = (wr_i && (addr_i == `OFS_IRQ_MASK)) ? wdata_i[2:0] : irq_mask_r;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat_r <= `RST_IRQ;
      irq_r <= 1'b0;
    end else if (set_default_i) begin
      irq_stat_r <= `RST_IRQ;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_nxt); // [R14] [R15] [R16]
    end
  end

  // read data valid only in the cycle after the strobe
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= 8'h00;
    end else if (!rd_i) begin
      rdata_r <= 8'h00;
    end else if (addr_i == `OFS_CAP_CTRL) begin
      rdata_r <= cap_ctrl_r;
    end else if (addr_i == `OFS_CAP_READBACK) begin
      rdata_r <= cap_rb_r; // [R04]
    end else if (addr_i == `OFS_AUX_STATUS) begin
      rdata_r <= aux_r; // [R05]
    end else if (addr_i == `OFS_WAKE_CTRL) begin
      rdata_r <= wake_ctrl_r;
    end else if (addr_i == `OFS_AMP_CFG) begin
      rdata_r <= amp_cfg_r;
    end else if (addr_i == `OFS_AMP_REF) begin
      rdata_r <= amp_ref_r;
    end else if (addr_i == `OFS_PHASE_CFG) begin
      rdata_r <= ph_cfg_r;
    end else if (addr_i == `OFS_PHASE_REF) begin
      rdata_r <= ph_ref_r;
    end else if (addr_i == `OFS_IRQ_STATUS) begin
      rdata_r <= {5'h00, irq_stat_r};
    end else if (addr_i == `OFS_IRQ_MASK) begin
      rdata_r <= {5'h00, irq_mask_r};
    end else if (addr_i == `OFS_WAKE_ENABLE) begin
      rdata_r <= {7'h00, wake_en_r};
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata_o = rdata_r;
  assign cap_cal_manual_o = mcal_r;
  assign auto_cal_en_o = auto_cal_r;
  assign gain_mv_per_pf_o = gain_mv_r;
  assign gain_valid_o = gain_ok_r;
  assign amp_meas_req_o = amp_req_r;
  assign phase_meas_req_o = ph_req_r;
  assign wake_timeout_o = expire_r;
  assign irq_o = irq_r;

endmodule

// [wakeup_timer_and_sense_status_bench.sv]
`timescale 1ns/10ps
`include "wakeup_timer_map.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end

module wakeup_timer_and_sense_status_bench;
  localparam int STEP = 4;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic set_default_i = 1'b0;
  logic [7:0] st = 8'h00;
  logic [4:0] cal_value_i = 5'h00;
  logic cal_done_i = 1'b0;
  logic cal_error_i = 1'b0;
  logic amp_done_i = 1'b0;
  logic phase_done_i = 1'b0;
  logic [7:0] amp_result_i = 8'h00;
  logic [7:0] amp_avg_ref_i = 8'h40;
  logic [7:0] phase_result_i = 8'h00;
  wire [7:0] rdata_o;
  wire [4:0] cap_cal_manual_o;
  wire [12:0] gain_mv_per_pf_o;
  wire auto_cal_en_o, gain_valid_o, amp_meas_req_o, phase_meas_req_o, wake_timeout_o, irq_o;
  wire [2:0] ev = {phase_meas_req_o, amp_meas_req_o, wake_timeout_o};
  int n_mismatch = 0;
  int n_checks = 0;
  int n;
  logic [7:0] d;
  logic [12:0] mv [8] = '{13'haf0, 13'h1964, 13'h44c, 13'h0, 13'h1f4, 13'h0, 13'h15e, 13'h0};

  always #5 ref_clk_i = ~ref_clk_i;

  wakeup_timer_and_sense_status #(.STEP_CYCLES(STEP)) u_dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .set_default_i(set_default_i),
    .chan_sel_pm_i(st[7]), .ext_field_i(st[6]), .tx_active_i(st[5]), .osc_stable_i(st[4]),
    .rx_enabled_i(st[3]), .rx_receiving_i(st[2]), .peer_detect_i(st[1]),
    .collision_avoid_active_i(st[0]), .cal_value_i(cal_value_i), .cal_done_i(cal_done_i),
    .cal_error_i(cal_error_i), .cap_cal_manual_o(cap_cal_manual_o),
    .auto_cal_en_o(auto_cal_en_o), .gain_mv_per_pf_o(gain_mv_per_pf_o),
    .gain_valid_o(gain_valid_o), .amp_meas_req_o(amp_meas_req_o), .amp_done_i(amp_done_i),
    .amp_result_i(amp_result_i), .amp_avg_ref_i(amp_avg_ref_i),
    .phase_meas_req_o(phase_meas_req_o), .phase_done_i(phase_done_i),
    .phase_result_i(phase_result_i), .wake_timeout_o(wake_timeout_o), .irq_o(irq_o)
  );

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task wr(input [7:0] a, input [7:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task rd(input [7:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // edges until the chosen event pulse is seen
  task wait_hi(input int sel, output int k);
    for (k = 1; k < 2000; k++) begin
      @(posedge ref_clk_i);
      if (ev[sel] === 1'b1)
        break;
    end
    if (k == 2000) begin
      n_mismatch++;
      $display("MISMATCH t=%0t event wait expired", $time);
      end_of_test;
    end
  endtask

  task t_reset;
    logic [7:0] a [5] = '{`OFS_CAP_CTRL, `OFS_CAP_READBACK, `OFS_AUX_STATUS, `OFS_WAKE_CTRL, 8'h00};
    foreach (a[i]) begin
      rd(a[i]);
      `CHK(d, 8'h00)
    end
    $display("reset values test done");
  endtask

  task t_gain;
    for (int c = 0; c < 8; c++) begin
      wr(`OFS_CAP_CTRL, {c[2:0], c[1:0], c[2:0]});
      #1;
      `CHK(cap_cal_manual_o, {c[2:0], c[1:0]})
      `CHK(auto_cal_en_o, c == 0)
      `CHK(gain_mv_per_pf_o, mv[c])
      `CHK(gain_valid_o, mv[c] != 13'd0)
    end
    $display("calibration and gain test done");
  endtask

  task t_readback;
    cal_value_i <= 5'h15;
    cal_error_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    cal_done_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    wr(`OFS_CAP_READBACK, 8'hff);
    rd(`OFS_CAP_READBACK);
    `CHK(d, 8'hae)
    cal_done_i <= 1'b0;
    $display("readback test done");
  endtask

  task t_aux;
    for (int i = 0; i < 8; i++) begin
      st <= 8'h80 >> i;
      repeat (4) @(posedge ref_clk_i);
      rd(`OFS_AUX_STATUS);
      `CHK(d, 8'h80 >> i)
    end
    st <= 8'h00;
    $display("aux status test done");
  endtask

  task t_timer;
    wr(`OFS_WAKE_ENABLE, 8'h01);
    wr(`OFS_IRQ_MASK, 8'h07);
    wr(`OFS_WAKE_CTRL, 8'hb8);
    wait_hi(0, n);
    wait_hi(0, n);
    `CHK(n, STEP * 4)
    rd(`OFS_IRQ_STATUS);
    `CHK(d[0], 1'b1)
    `CHK(irq_o, 1'b1)
    wr(`OFS_WAKE_CTRL, 8'h08);
    wait_hi(0, n);
    wait_hi(0, n);
    `CHK(n, STEP * 10)
    wr(`OFS_IRQ_MASK, 8'h00);
    #1;
    `CHK(irq_o, 1'b0)
    wr(`OFS_WAKE_CTRL, 8'h00);
    wr(`OFS_IRQ_MASK, 8'h07);
    $display("timer test done");
  endtask

  task t_meas(input [7:0] ctl, input [7:0] cfg, input [7:0] rf, input [7:0] res, input e);
    wr(`OFS_IRQ_STATUS, 8'h07);
    wr(ctl[1] ? `OFS_PHASE_CFG : `OFS_AMP_CFG, cfg);
    wr(ctl[1] ? `OFS_PHASE_REF : `OFS_AMP_REF, rf);
    wr(`OFS_WAKE_CTRL, ctl);
    wait_hi(ctl[1] ? 2 : 1, n);
    amp_result_i <= res;
    phase_result_i <= res;
    amp_done_i <= ctl[2];
    phase_done_i <= ctl[1];
    @(posedge ref_clk_i);
    amp_done_i <= 1'b0;
    phase_done_i <= 1'b0;
    wr(`OFS_WAKE_CTRL, 8'h00);
    rd(`OFS_IRQ_STATUS);
    `CHK(d[ctl[1] ? 2 : 1], e)
    `CHK(irq_o, e)
    $display("measurement test done");
  endtask

  task t_default;
    wr(`OFS_CAP_CTRL, 8'hff);
    wr(`OFS_WAKE_CTRL, 8'hfe);
    @(posedge ref_clk_i);
    set_default_i <= 1'b1;
    @(posedge ref_clk_i);
    set_default_i <= 1'b0;
    rd(`OFS_CAP_CTRL);
    `CHK(d, 8'h00)
    rd(`OFS_WAKE_CTRL);
    `CHK(d, 8'h00)
    rd(`OFS_CAP_READBACK);
    `CHK(d, 8'h00)
    $display("set default test done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_reset;
    t_gain;
    t_readback;
    t_aux;
    t_timer;
    t_meas(8'h84, 8'h30, 8'h10, 8'h14, 1'b1);
    t_meas(8'h84, 8'h30, 8'h10, 8'h13, 1'b0);
    t_meas(8'h84, 8'h31, 8'h10, 8'h12, 1'b1);
    t_meas(8'h82, 8'h30, 8'h18, 8'h14, 1'b1);
    t_meas(8'h82, 8'h40, 8'h18, 8'h14, 1'b0);
    t_default;
    end_of_test;
  end
endmodule

// [wakeup_timer_and_sense_status_properties.sv]
`timescale 1ns/10ps
`include "wakeup_timer_map.vh"

module wakeup_timer_checker #(
  parameter STEP_CYCLES = 4
) (
  // clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire set_default_i,
  // observed outputs
  input wire [4:0] cap_cal_manual_o,
  input wire auto_cal_en_o,
  input wire [12:0] gain_mv_per_pf_o,
  input wire gain_valid_o,
  input wire amp_meas_req_o,
  input wire phase_meas_req_o,
  input wire wake_timeout_o,
  input wire irq_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_cap_wr;
    wr_i && addr_i == `OFS_CAP_CTRL && !set_default_i;
  endsequence
  sequence s_quiet3;
    !wake_timeout_o [*3];
  endsequence

  property p_cap_wr;
    s_cap_wr |=> cap_cal_manual_o == $past(wdata_i[7:3]);
  endproperty
  property p_auto;
    auto_cal_en_o == (cap_cal_manual_o == 5'h00);
  endproperty
  property p_gain;
    gain_valid_o == (gain_mv_per_pf_o != 12'h000);
  endproperty
  property p_rd_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  property p_rb_bit0;
    rd_i && addr_i == `OFS_CAP_READBACK |=> !rdata_o[0];
  endproperty
  property p_wake_bit0;
    rd_i && addr_i == `OFS_WAKE_CTRL |=> !rdata_o[0];
  endproperty
  property p_set_def;
    set_default_i |=> cap_cal_manual_o == 5'h00 && !irq_o;
  endproperty
  property p_tmo;
    wake_timeout_o |=> s_quiet3;
  endproperty
  property p_amp;
    $rose(amp_meas_req_o) |-> wake_timeout_o || $past(wake_timeout_o);
  endproperty
  property p_phase;
    $rose(phase_meas_req_o) |-> wake_timeout_o || $past(wake_timeout_o);
  endproperty

  a_cap_wr: assert property (p_cap_wr) else $error("manual cal field not written");
  a_auto: assert property (p_auto) else $error("auto cal enable wrong");
  a_gain: assert property (p_gain) else $error("gain valid wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_rb_bit0: assert property (p_rb_bit0) else $error("readback bit0 set");
  a_wake_bit0: assert property (p_wake_bit0) else $error("wake ctrl bit0 set");
  a_set_def: assert property (p_set_def) else $error("set default no clear");
  a_tmo: assert property (p_tmo) else $error("timeouts too close");
  a_amp: assert property (p_amp) else $error("amp request w/o timeout");
  a_phase: assert property (p_phase) else $error("phase request w/o timeout");
endmodule

bind wakeup_timer_and_sense_status wakeup_timer_checker #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .set_default_i(set_default_i),
  .cap_cal_manual_o(cap_cal_manual_o),
  .auto_cal_en_o(auto_cal_en_o),
  .gain_mv_per_pf_o(gain_mv_per_pf_o),
  .gain_valid_o(gain_valid_o),
  .amp_meas_req_o(amp_meas_req_o),
  .phase_meas_req_o(phase_meas_req_o),
  .wake_timeout_o(wake_timeout_o),
  .irq_o(irq_o)
);

// [wakeup_timer_map.vh]
`ifndef WAKEUP_TIMER_MAP_VH
`define WAKEUP_TIMER_MAP_VH

// register offsets
`define OFS_CAP_CTRL 8'h2e
`define OFS_CAP_READBACK 8'h2f
`define OFS_AUX_STATUS 8'h30
`define OFS_WAKE_CTRL 8'h31
`define OFS_AMP_CFG 8'h32
`define OFS_AMP_REF 8'h33
`define OFS_PHASE_CFG 8'h36
`define OFS_PHASE_REF 8'h37
`define OFS_IRQ_STATUS 8'h40
`define OFS_IRQ_MASK 8'h41
`define OFS_WAKE_ENABLE 8'h42

// reset values
`define RST_BYTE 8'h00
`define RST_IRQ 3'h0

// capacitive sensor control fields
`define CAP_MCAL_HI 7
`define CAP_MCAL_LO 3
`define CAP_GAIN_HI 2
`define CAP_GAIN_LO 0

// sensor gain codes and values in mV/pF
`define GAIN_CODE_0 3'h0
`define GAIN_CODE_1 3'h1
`define GAIN_CODE_2 3'h2
`define GAIN_CODE_4 3'h4
`define GAIN_CODE_6 3'h6
`define GAIN_MV_0 13'haf0
`define GAIN_MV_1 13'h1964
`define GAIN_MV_2 13'h44c
`define GAIN_MV_4 13'h1f4
`define GAIN_MV_6 13'h15e

// wake-up control fields
`define WAKE_RANGE_BIT 7
`define WAKE_TMO_HI 6
`define WAKE_TMO_LO 4
`define WAKE_IRQ_BIT 3
`define WAKE_AMP_BIT 2
`define WAKE_PHASE_BIT 1

// measurement config fields
`define THR_HI 7
`define THR_LO 4
`define AMP_REF_SEL_BIT 0

// interrupt status bits
`define IRQ_TIMEOUT 0
`define IRQ_AMP 1
`define IRQ_PHASE 2

// timing
`define CLK_PERIOD_NS 10
`define SHORT_STEP_NS 10000000
`define LONG_PER_SHORT 7'h0a

`endif
